/* logic/lgcf_cfg.svh */
// Offsets, field positions and reset values of the LED frame register bank.
// Assumes inclusion by lgcf_pkg and by the design modules of this block.
`ifndef LGCF_CFG_SVH
`define LGCF_CFG_SVH

// ==========================================================================
// Frame geometry
`define LGCF_FRAME_W        288
`define LGCF_SHIFT_W        289
`define LGCF_CNT_W          9
`define LGCF_CHANNELS       8
`define LGCF_GS_W           12
`define LGCF_GS_PITCH       36
`define LGCF_GS_SECOND_OFS  24
`define LGCF_DC_W           7
`define LGCF_DC_PITCH       21
`define LGCF_DC_SECOND_OFS  14

// ==========================================================================
// Frame select: offset of the configuration frame, carried in the top bit
`define LGCF_CFG_OFFSET     1'h1

// ==========================================================================
// Configuration frame fields
`define LGCF_CMD_HI         287
`define LGCF_CMD_LO         276
`define LGCF_MASK_BIT       204
`define LGCF_SLEW_BIT       203
`define LGCF_OPEN_V_BIT     202
`define LGCF_SHORT_V_BIT    201
`define LGCF_APS_CUR_BIT    200
`define LGCF_APS_TIME_BIT   199
`define LGCF_MODE_HI        198
`define LGCF_MODE_LO        197
`define LGCF_TIMING_BIT     196
`define LGCF_REPEAT_BIT     195
`define LGCF_RANGE_B_BIT    194
`define LGCF_RANGE_R_BIT    192
`define LGCF_BC_B_HI        191
`define LGCF_BC_B_LO        184
`define LGCF_BC_R_HI        175
`define LGCF_BC_R_LO        168

// ==========================================================================
// Command codes
`define LGCF_CMD_GRESET     12'h25C
`define LGCF_CMD_SELFTEST   12'h535
`define LGCF_CMD_APS        12'h53A
`define LGCF_CMD_NEGTOG     12'h55A
`define LGCF_CMD_IDREAD     12'h5A3
`define LGCF_CMD_CFGREAD    12'h5AC
`define LGCF_CMD_GSREAD     12'h5AF
`define LGCF_CMD_ERRCLR     12'hA53

// ==========================================================================
// Reset values
`define LGCF_GS_RESET       288'h0
`define LGCF_CFG_RESET      (288'h1 << `LGCF_MASK_BIT)
// Identification word, value arbitrary
`define LGCF_ID_VALUE       16'hA5C3

`endif

/* logic/lgcf_pkg.sv */
// Types shared by the LED frame register bank modules.
// Assumes lgcf_cfg.svh is on the include path.
`include "lgcf_cfg.svh"

package lgcf_pkg;

  // ========================================================================
  // Grayscale counter width
  typedef enum logic [1:0] {
    LGCF_CNT12 = 2'h0,
    LGCF_CNT10 = 2'h1,
    LGCF_CNT8  = 2'h3
  } lgcf_width_e;

  // ========================================================================
  // One-hot command strobes
  typedef struct packed {
    logic greset;
    logic selftest;
    logic aps;
    logic negtog;
    logic idread;
    logic cfgread;
    logic gsread;
    logic errclr;
  } lgcf_cmd_s;

  // ========================================================================
  // Control bits of the configuration frame
  typedef struct packed {
    logic       led_fault_mask;
    logic       slew_slow;
    logic       open_v_high;
    logic       short_v_high;
    logic       aps_cur_high;
    logic       aps_time_long;
    logic [1:0] counter_width_select;
    logic       timing_reset;
    logic       auto_repeat;
    logic       range_b_high;
    logic       range_r_high;
    logic [7:0] second_group_brightness;
    logic [7:0] first_group_brightness;
  } lgcf_ctrl_s;

  // ========================================================================
  // Control state of the frame loader
  typedef enum logic [1:0] {
    LGCF_IDLE  = 2'b00,
    LGCF_SHIFT = 2'b01,
    LGCF_APPLY = 2'b11
  } lgcf_state_e;

endpackage : lgcf_pkg

/* logic/lgcf_cmd_decode.sv */
// Command and counter width decoder of the LED frame register bank.
// Assumes a stable command field from the configuration frame register.
`timescale 1ns/1ps
`include "lgcf_cfg.svh"

module lgcf_cmd_decode
  import lgcf_pkg::*;
(
  input  wire logic [11:0] cmd,
  input  wire logic [1:0]  mode,
  output lgcf_cmd_s        strobes,
  output lgcf_width_e      width
);

  // ==========================================================================
  // Command match
  function automatic logic is_cmd(input logic [11:0] c, input logic [11:0] code);
    is_cmd = (c == code);
  endfunction : is_cmd

  // Unlisted codes give no strobe at all
  assign strobes.greset   = is_cmd(cmd, `LGCF_CMD_GRESET);
  assign strobes.selftest = is_cmd(cmd, `LGCF_CMD_SELFTEST);
  assign strobes.aps      = is_cmd(cmd, `LGCF_CMD_APS);
  assign strobes.negtog   = is_cmd(cmd, `LGCF_CMD_NEGTOG);
  assign strobes.idread   = is_cmd(cmd, `LGCF_CMD_IDREAD);
  assign strobes.cfgread  = is_cmd(cmd, `LGCF_CMD_CFGREAD);
  assign strobes.gsread   = is_cmd(cmd, `LGCF_CMD_GSREAD);
  assign strobes.errclr   = is_cmd(cmd, `LGCF_CMD_ERRCLR);

  // ==========================================================================
  // Counter width: 0 and 1 both mean 12 bits
  assign width = (mode == 2'h2) ? LGCF_CNT10 :
                 (mode == 2'h3) ? LGCF_CNT8  : LGCF_CNT12;

endmodule : lgcf_cmd_decode

/* logic/lgcf_top.sv */
// LED grayscale and configuration frame register bank with serial access.
// Assumes sdi, sclk and lat are synchronous to clk and change slower than it.
`timescale 1ns/1ps
`include "lgcf_cfg.svh"

// Behaviour
// - Lowest first-group gray value sits in bits 11..0, reserved 23..12, second-group 35..24.
// - The gray frame is 288 bits with the highest channel in bits 287..252.
// - Each channel index repeats the 36-bit layout, index three spanning bits 143..108.
// - Every gray field and reserved slot is 12 bits, read/write, and zero after reset.
// - The configuration frame is the only listed register, reached at offset one.
// - The 12-bit command field is decoded into eight commands, others doing nothing.
// - Counter mode 0 or 1 selects 12-bit, 2 selects 10-bit and 3 selects 8-bit counting.
// - The LED fault mask resets to one, masking faults, and a zero unmasks them.
module lgcf_top
  import lgcf_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   sdi,
  input  wire logic                   sclk,
  input  wire logic                   lat,
  input  wire logic [15:0]            led_fault_in,
  output logic                        sdo,
  output logic [7:0][11:0]            first_group_gray_value,
  output logic [7:0][11:0]            second_group_gray_value,
  output logic [7:0][6:0]             first_group_dot_correction,
  output logic [7:0][6:0]             second_group_dot_correction,
  output lgcf_ctrl_s                  ctrl,
  output lgcf_width_e                 counter_width,
  output logic                        selftest_pulse,
  output logic                        aps_check_pulse,
  output logic                        negate_toggle,
  output logic [15:0]                 led_fault_status,
  output logic                        led_fault
);

  // ==========================================================================
  // Storage
  logic [`LGCF_SHIFT_W-1:0] shift_r;
  logic [`LGCF_SHIFT_W-1:0] shift_nxt;
  logic [`LGCF_CNT_W-1:0]   count_r;
  logic [`LGCF_CNT_W-1:0]   count_nxt;
  logic [`LGCF_FRAME_W-1:0] gray_r;
  logic [`LGCF_FRAME_W-1:0] config_r;
  logic                     sclk_r;
  logic                     lat_r;
  lgcf_state_e              state_r;
  lgcf_state_e              state_nxt;
  logic                     selftest_r;
  logic                     aps_r;
  logic                     negate_r;
  logic [15:0]              fault_r;
  logic [15:0]              fault_nxt;

  // ==========================================================================
  // Pin edge detection
  logic sclk_rise;
  logic lat_rise;
  logic word_full;
  logic good_latch;
  logic latch_cfg;
  logic latch_gray;

  assign sclk_rise  = sclk & ~sclk_r;
  assign lat_rise   = lat & ~lat_r;
  assign word_full  = (count_r == 9'(`LGCF_SHIFT_W));
  assign good_latch = lat_rise & word_full;
  assign latch_cfg  = good_latch & (shift_r[`LGCF_FRAME_W] == `LGCF_CFG_OFFSET);
  assign latch_gray = good_latch & (shift_r[`LGCF_FRAME_W] != `LGCF_CFG_OFFSET);

  // ==========================================================================
  // Command decode of the stored configuration frame
  lgcf_cmd_s strobes;
  logic      do_cmd;

  lgcf_cmd_decode u_decode (
    .cmd     (config_r[`LGCF_CMD_HI:`LGCF_CMD_LO]),
    .mode    (config_r[`LGCF_MODE_HI:`LGCF_MODE_LO]),
    .strobes (strobes),
    .width   (counter_width)
  );

  // Commands act once, in the cycle after the configuration latch
  assign do_cmd = (state_r == LGCF_APPLY);

  // ==========================================================================
  // Readback word selection
  logic [`LGCF_FRAME_W-1:0] read_word;
  logic                     read_load;

  assign read_load = do_cmd & (strobes.idread | strobes.cfgread | strobes.gsread);
  assign read_word = strobes.gsread  ? gray_r :
                     strobes.cfgread ? config_r :
                     {{(`LGCF_FRAME_W-16){1'b0}}, `LGCF_ID_VALUE};

  // ==========================================================================
  // Shift register and bit counter
  always_comb begin
    shift_nxt = shift_r;
    count_nxt = count_r;
    if (read_load) begin
      shift_nxt = {1'b0, read_word};
      count_nxt = '0;
    end else if (sclk_rise) begin
      shift_nxt = {shift_r[`LGCF_SHIFT_W-2:0], sdi};
      if (!word_full) begin
        count_nxt = count_r + 9'h1;
      end
    end else if (lat_rise) begin
      count_nxt = '0;
    end
  end

  // ==========================================================================
  // Loader state
  always_comb begin
    case (state_r)
      LGCF_IDLE:  state_nxt = sclk_rise ? LGCF_SHIFT : LGCF_IDLE;
      LGCF_SHIFT: state_nxt = latch_cfg ? LGCF_APPLY :
                              lat_rise  ? LGCF_IDLE  : LGCF_SHIFT;
      LGCF_APPLY: state_nxt = LGCF_IDLE;
      default:    state_nxt = LGCF_IDLE;
    endcase
  end

  // ==========================================================================
  // Sticky fault flags: a new fault wins over the clear
  assign fault_nxt = (do_cmd & (strobes.errclr | strobes.greset)) ?
                     led_fault_in : (fault_r | led_fault_in);

  // ==========================================================================
  // Sampling registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_r  <= 1'b0;
      lat_r   <= 1'b0;
      state_r <= LGCF_IDLE;
      shift_r <= '0;
      count_r <= '0;
      fault_r <= 16'h0000;
    end else begin
      sclk_r  <= sclk;
      lat_r   <= lat;
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      count_r <= count_nxt;
      fault_r <= fault_nxt;
    end
  end

  // ==========================================================================
  // Frame registers; global reset restores defaults
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gray_r   <= `LGCF_GS_RESET;
      config_r <= `LGCF_CFG_RESET;
    end else if (do_cmd && strobes.greset) begin
      gray_r   <= `LGCF_GS_RESET;
      config_r <= `LGCF_CFG_RESET;
    end else if (latch_gray) begin
      gray_r   <= shift_r[`LGCF_FRAME_W-1:0];
    end else if (latch_cfg) begin
      config_r <= shift_r[`LGCF_FRAME_W-1:0];
    end
  end

  // ==========================================================================
  // Diagnostic command outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      selftest_r <= 1'b0;
      aps_r      <= 1'b0;
      negate_r   <= 1'b0;
    end else begin
      selftest_r <= do_cmd & strobes.selftest;
      aps_r      <= do_cmd & strobes.aps;
      negate_r   <= negate_r ^ (do_cmd & strobes.negtog);
    end
  end

  assign selftest_pulse   = selftest_r;
  assign aps_check_pulse  = aps_r;
  assign negate_toggle    = negate_r;
  assign led_fault_status = fault_r;
  // Mask high hides all LED faults from led_fault; led_fault_status still shows them
  assign led_fault        = (|fault_r) & ~config_r[`LGCF_MASK_BIT];

  // ==========================================================================
  // Serial out: top bit of the shift register feeds the next device
  assign sdo = shift_r[`LGCF_SHIFT_W-1];

  // ==========================================================================
  // Per-channel field extraction
  genvar ch;
  generate
    for (ch = 0; ch < `LGCF_CHANNELS; ch++) begin : g_chan
      localparam int GS_BASE = ch * `LGCF_GS_PITCH;
      localparam int DC_BASE = ch * `LGCF_DC_PITCH;
      // First group at the base, reserved slot, then second group
      assign first_group_gray_value[ch] =
        gray_r[GS_BASE +: `LGCF_GS_W];
      assign second_group_gray_value[ch] =
        gray_r[GS_BASE + `LGCF_GS_SECOND_OFS +: `LGCF_GS_W];
      assign first_group_dot_correction[ch] =
        config_r[DC_BASE +: `LGCF_DC_W];
      assign second_group_dot_correction[ch] =
        config_r[DC_BASE + `LGCF_DC_SECOND_OFS +: `LGCF_DC_W];
    end
  endgenerate

  // Highest channel tops out at bit 287 of the gray frame

  // ==========================================================================
  // Control bit fields of the configuration frame
  assign ctrl.led_fault_mask          = config_r[`LGCF_MASK_BIT];
  assign ctrl.slew_slow               = config_r[`LGCF_SLEW_BIT];
  assign ctrl.open_v_high             = config_r[`LGCF_OPEN_V_BIT];
  assign ctrl.short_v_high            = config_r[`LGCF_SHORT_V_BIT];
  assign ctrl.aps_cur_high            = config_r[`LGCF_APS_CUR_BIT];
  assign ctrl.aps_time_long           = config_r[`LGCF_APS_TIME_BIT];
  assign ctrl.counter_width_select    = config_r[`LGCF_MODE_HI:`LGCF_MODE_LO];
  assign ctrl.timing_reset            = config_r[`LGCF_TIMING_BIT];
  assign ctrl.auto_repeat             = config_r[`LGCF_REPEAT_BIT];
  assign ctrl.range_b_high            = config_r[`LGCF_RANGE_B_BIT];
  assign ctrl.range_r_high            = config_r[`LGCF_RANGE_R_BIT];
  assign ctrl.second_group_brightness = config_r[`LGCF_BC_B_HI:`LGCF_BC_B_LO];
  assign ctrl.first_group_brightness  = config_r[`LGCF_BC_R_HI:`LGCF_BC_R_LO];

endmodule : lgcf_top

/* sim/lgcf_host_model.sv */
// Host model: shifts the top n bits of 289-bit words into the frame bank and latches them.
// Assumes the bank samples sdi, sclk and lat on the rising edge of clk.
`timescale 1ns/1ps

module lgcf_host_model (
  input  wire logic clk,
  output logic      sdi,
  output logic      sclk,
  output logic      lat
);
  // ====================
  // Idle levels
  initial begin
    sdi  = 1'b0;
    sclk = 1'b0;
    lat  = 1'b0;
  end

  // ====================
  // Send the top n bits MSB first, then latch
  task automatic send(input logic sel, input logic [287:0] frame, input int n);
    logic [288:0] word;
    word = {sel, frame};
    for (int i = 288; i > 288 - n; i--) begin
      @(negedge clk);
      sclk <= 1'b0;
      sdi  <= word[i];
      repeat (2) @(negedge clk);
      sclk <= 1'b1;
      @(negedge clk);
    end
    @(negedge clk);
    sclk <= 1'b0;
    sdi  <= ~sdi;  // Released line shows no stale bit
    repeat (2) @(negedge clk);
    lat <= 1'b1;
    repeat (2) @(negedge clk);
    lat <= 1'b0;
    repeat (6) @(negedge clk);
  endtask : send
endmodule : lgcf_host_model

/* sim/lgcf_assertions.sv */
// Checker of the LED frame bank, bound to its top module.
// Assumes lat pulses stay high for at least one clock.
`timescale 1ns/1ps

module lgcf_checker
  import lgcf_pkg::*;
(
  input wire logic             clk,
  input wire logic             rst,
  input wire logic             lat,
  input wire logic [7:0][11:0] first_group_gray_value,
  input wire lgcf_ctrl_s       ctrl,
  input wire lgcf_width_e      counter_width,
  input wire logic             selftest_pulse,
  input wire logic             aps_check_pulse,
  input wire logic             negate_toggle,
  input wire logic [15:0]      led_fault_status,
  input wire logic             led_fault
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ====================
  // Recent latch history
  logic [3:0] lat_q_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) lat_q_r <= 4'h0;
    else lat_q_r <= {lat_q_r[2:0], lat};
  end

  // ====================
  // Properties
  width_map_a: assert property (counter_width == (ctrl.counter_width_select[1] ?
    (ctrl.counter_width_select[0] ? LGCF_CNT8 : LGCF_CNT10) : LGCF_CNT12))
    else $error("counter width does not follow mode field");
  mask_hides_a: assert property (ctrl.led_fault_mask |-> !led_fault)
    else $error("fault shown while masked");
  unmask_shows_a: assert property (!ctrl.led_fault_mask |-> led_fault == |led_fault_status)
    else $error("fault flag differs from status");
  reset_value_a: assert property ($fell(rst) |-> first_group_gray_value == '0
    && ctrl.led_fault_mask) else $error("wrong values after reset");
  gray_hold_a: assert property ($changed(first_group_gray_value) |-> |lat_q_r)
    else $error("gray changed without latch");
  pulse_once_a: assert property (selftest_pulse |-> |lat_q_r ##1 !selftest_pulse)
    else $error("self test pulse misplaced");
  aps_once_a: assert property ($rose(aps_check_pulse) |-> |lat_q_r ##1 $fell(aps_check_pulse))
    else $error("adjacent check pulse misplaced");
  negate_hold_a: assert property ($changed(negate_toggle) |-> |lat_q_r)
    else $error("negate toggled without latch");
  fault_sticky_a: assert property (|($past(led_fault_status) & ~led_fault_status)
    |-> |lat_q_r) else $error("fault flag cleared without command");

  // ====================
  // Main scenarios
  cover property (selftest_pulse);
  cover property ($changed(negate_toggle));
  cover property (led_fault);
endmodule : lgcf_checker

bind lgcf_top lgcf_checker u_chk (.clk(clk), .rst(rst), .lat(lat),
  .first_group_gray_value(first_group_gray_value), .ctrl(ctrl),
  .counter_width(counter_width), .selftest_pulse(selftest_pulse),
  .aps_check_pulse(aps_check_pulse), .negate_toggle(negate_toggle),
  .led_fault_status(led_fault_status), .led_fault(led_fault));

/* sim/test_led_gray_config_frames.sv */
// Bench for the LED frame bank: gray and config writes, commands, faults.
// Assumes the host model drives the serial pins at the falling clock edge.
`timescale 1ns/1ps

module test_led_gray_config_frames
  import lgcf_pkg::*;
;
  logic             clk, rst, sdi, sclk, lat, sdo;
  logic             selftest_pulse, aps_check_pulse, negate_toggle, led_fault;
  logic [15:0]      led_fault_in, led_fault_status;
  logic [7:0][11:0] first_group_gray_value, second_group_gray_value, ef, es;
  logic [7:0][6:0]  first_group_dot_correction, second_group_dot_correction;
  lgcf_ctrl_s       ctrl;
  lgcf_width_e      counter_width;
  logic [287:0]     g, c;
  logic [11:0]      codes [7] = '{12'h535, 12'h53A, 12'h55A, 12'h5A3, 12'h5AC, 12'h5AF, 12'h123};
  logic [1:0]       cw_exp [4] = '{2'h0, 2'h0, 2'h1, 2'h3};
  int               n_errors = 0, checked = 0, n_self = 0, n_aps = 0;

  lgcf_top u_dut (.clk, .rst, .sdi, .sclk, .lat, .led_fault_in, .sdo, .first_group_gray_value,
    .second_group_gray_value, .first_group_dot_correction, .second_group_dot_correction, .ctrl,
    .counter_width, .selftest_pulse, .aps_check_pulse, .negate_toggle, .led_fault_status,
    .led_fault);
  lgcf_host_model u_host (.clk, .sdi, .sclk, .lat);

  // ====================
  // Clock and pulse counters
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(negedge clk) begin
    if (selftest_pulse === 1'b1) n_self++;
    if (aps_check_pulse === 1'b1) n_aps++;
  end

  // ====================
  // Compare, config write and verdict
  task chk(input logic [95:0] got, input logic [95:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : chk
  task cfg(input logic [11:0] cmd, input logic [1:0] m, input logic mask);
    c = '0;
    c[287:276] = cmd;
    c[204] = mask;
    c[198:197] = m;
    c[191:184] = 8'h5A;
    c[175:168] = 8'hC3;
    c[6:0] = 7'h55;
    c[20:14] = 7'h2A;
    u_host.send(1'b1, c, 289);
  endtask : cfg
  task summarize;
    if (n_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  // ====================
  // Watchdog
  initial begin
    #2_000_000;
    n_errors++;
    $display("unexpected at %0t: timeout", $time);
    summarize();
  end

  // ====================
  // Tests
  initial begin
    rst = 1'b1;
    led_fault_in = 16'h0000;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk(96'(first_group_gray_value), 96'h0, "gray reset");
    chk(96'(ctrl.led_fault_mask), 96'h1, "mask reset");
    chk(96'(counter_width), 96'(LGCF_CNT12), "width reset");
    g = '1;
    for (int i = 0; i < 8; i++) begin
      g[36*i +: 12] = 12'h0A0 + 12'(i);
      g[36*i+24 +: 12] = 12'h0B0 + 12'(i);
      ef[i] = 12'h0A0 + 12'(i);
      es[i] = 12'h0B0 + 12'(i);
    end
    u_host.send(1'b0, g, 289);
    chk(first_group_gray_value, ef, "first group layout");
    chk(second_group_gray_value, es, "second group layout");
    u_host.send(1'b0, ~g, 200);
    chk(first_group_gray_value, ef, "partial frame applied");
    for (int m = 0; m < 4; m++) begin
      cfg(12'h000, 2'(m), 1'b0);
      chk(96'(counter_width), 96'(cw_exp[m]), "counter width");
    end
    chk(96'(ctrl.led_fault_mask), 96'h0, "mask write");
    chk(96'({ctrl.second_group_brightness, ctrl.first_group_brightness}), 96'h5AC3, "bright");
    chk(96'({first_group_dot_correction[0], second_group_dot_correction[0]}), 96'h2AAA, "dot");
    chk(first_group_gray_value, ef, "config write hit gray");
    foreach (codes[k]) begin
      cfg(codes[k], 2'h0, 1'b0);
      // Read commands reload the shift register, so its top bit drops to zero
      chk(96'(sdo), 96'(k < 3 || k > 5), "serial out after command");
      if (k == 3) begin
        u_host.send(1'b0, '0, 273);
        // Bit 15 of the arbitrary id word reaches the serial output
        chk(96'(sdo), 96'h1, "id readback");
      end
    end
    chk(96'(n_self), 96'h1, "self test count");
    chk(96'(n_aps), 96'h1, "adjacent check count");
    chk(96'(negate_toggle), 96'h1, "negate toggle");
    @(negedge clk);
    led_fault_in = 16'h0004;
    repeat (3) @(negedge clk);
    chk(96'({led_fault_status, led_fault}), 96'h0_0009, "fault shown");
    led_fault_in = 16'h0000;
    cfg(12'hA53, 2'h0, 1'b0);
    chk(96'({led_fault_status, led_fault}), 96'h0, "error clear");
    cfg(12'h25C, 2'h3, 1'b0);
    chk(96'(first_group_gray_value), 96'h0, "global reset gray");
    chk(96'({ctrl.led_fault_mask, counter_width}), 96'h4, "global reset config");
    summarize();
  end
endmodule : test_led_gray_config_frames
